// file: csactl_pkg.sv
// Package for the current sense amplifier control register bank.
// Assumes a single core clock domain and an SPI frame decoder outside the bank.
package csactl_pkg;

    localparam int          CSACTL_ADDR_W       = 4;
    localparam int          CSACTL_DATA_W       = 11;
    localparam logic [3:0]  CSACTL_ADDR_CSA     = 4'h6;
    localparam logic [10:0] CSACTL_RESET        = 11'h0_283;
    localparam int          CSACTL_BIT_INSEL    = 10;
    localparam int          CSACTL_BIT_REFHALF  = 9;
    localparam int          CSACTL_BIT_LSREF    = 8;
    localparam int          CSACTL_BIT_GAIN_LO  = 6;
    localparam int          CSACTL_BIT_SENDIS   = 5;
    localparam int          CSACTL_BIT_CAL_A    = 4;
    localparam int          CSACTL_BIT_CAL_B    = 3;
    localparam int          CSACTL_BIT_CAL_C    = 2;
    localparam int          CSACTL_BIT_TRIP_LO  = 0;
    localparam int          CSACTL_NUM_AMPS     = 3;
    localparam logic [1:0]  CSACTL_GAIN_5       = 2'h0;
    localparam logic [1:0]  CSACTL_GAIN_10      = 2'h1;
    localparam logic [1:0]  CSACTL_GAIN_20      = 2'h2;
    localparam logic [1:0]  CSACTL_GAIN_40      = 2'h3;

    typedef struct packed {
        logic       amp_input_select;
        logic       ref_halving_select;
        logic       lowside_vds_ref_select;
        logic [1:0] amp_gain_select;
        logic       sense_fault_disable;
        logic [2:0] amp_offset_cal;
        logic [1:0] sense_trip_level;
    } csactl_cfg_t;

    typedef struct packed {
        logic                     wr_en;
        logic                     rd_en;
        logic [CSACTL_ADDR_W-1:0] addr;
        logic [15:0]              wdata;
    } csactl_req_t;

endpackage

// file: csactl_field.sv
// Field splitter that turns the stored register word into decoded controls.
// Assumes the word is held in a flip-flop by the caller.
`timescale 1ns/1ps
`default_nettype none
module csactl_field (
    // Stored word
    input  wire logic [10:0]              word,
    // Decoded controls
    output var csactl_pkg::csactl_cfg_t   cfg
);
    import csactl_pkg::*;

    // The struct order matches the register bit order, so a cast suffices.
    assign cfg = csactl_cfg_t'(word);
endmodule
`default_nettype wire

// file: csactl_reg.sv
// Current sense amplifier control register bank with decoded analog controls.
// Assumes a sequenced SPI frame decoder hands over one-cycle read and write strobes.
//
// Contract
// - The configuration is a read-write register at address 0x06 whose fields can all be read back and overwritten.
// - The register exists only when the sense amplifiers are present; otherwise it is not implemented.
// - Bit 10 selects the amplifier positive input, sense positive pin at 0 and phase node pin at 1.
// - Writing bit 10 as 1 also forces the low-side reference bit to 1.
// - Bit 9 selects full reference at 0 or half reference at 1, and resets to 1.
// - Bit 8 selects low-side drain-source measurement to sense positive at 0 or sense negative at 1.
// - Bits 7-6 select gain 5, 10, 20 or 40 V/V and reset to 10.
// - Bit 5 at 1 suppresses the sense overcurrent fault.
// - Bits 4, 3 and 2 short the inputs of amplifiers A, B and C for offset calibration.
// - Bits 1-0 set the sense trip level 0.25 to 1 V and reset to 11.
// - Source and sink drive currents are set independently by registers on serial variants.
// - A gate drive fault may be raised when drive current is too low to switch in the window.
`timescale 1ns/1ps
`default_nettype none
module csactl_reg #(
    parameter bit HAS_AMPS = 1'b1
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    resetn,
    // Register access
    input  wire csactl_pkg::csactl_req_t req,
    output var  logic [15:0]             rdata,
    output var  logic                    rvalid,
    // Amplifier controls
    output var  logic                    sense_pos_sel,
    output var  logic                    phase_node_sel,
    output var  logic                    ref_half,
    output var  logic                    lowside_ref_neg,
    output var  logic [1:0]              amp_gain,
    output var  logic                    sense_fault_en,
    output var  logic [2:0]              amp_short,
    output var  logic [1:0]              trip_level,
    // Fault inputs and reported faults
    input  wire logic                    sense_oc_raw,
    output var  logic                    sense_oc_fault
);
    import csactl_pkg::*;

    logic [10:0]  word;
    logic [10:0]  next_word;
    logic [15:0]  next_rdata;
    logic         next_rvalid;
    csactl_cfg_t  cfg;
    logic         next_sense_pos_sel;
    logic         next_phase_node_sel;
    logic         next_ref_half;
    logic         next_lowside_ref_neg;
    logic [1:0]   next_amp_gain;
    logic         next_sense_fault_en;
    logic [2:0]   next_amp_short;
    logic [1:0]   next_trip_level;
    logic         next_sense_oc_fault;

    function automatic logic hit(input logic [3:0] a);
        hit = HAS_AMPS && (a == CSACTL_ADDR_CSA);
    endfunction

    always_comb begin
        next_word   = word;
        next_rdata  = 16'h0000;
        next_rvalid = 1'b0;
        if (req.wr_en && hit(req.addr)) begin
            next_word = req.wdata[10:0];
            if (req.wdata[CSACTL_BIT_INSEL]) begin
                next_word[CSACTL_BIT_LSREF] = 1'b1;
            end
        end
        if (req.rd_en) begin
            next_rvalid = 1'b1;
            if (hit(req.addr)) begin
                next_rdata = {5'h00, word};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            word   <= CSACTL_RESET;
            rdata  <= 16'h0000;
            rvalid <= 1'b0;
        end else begin
            word   <= next_word;
            rdata  <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    csactl_field u_field (
        .word (word),
        .cfg  (cfg)
    );

    // Drive-current and gate-drive fault settings live in other banks; this bank never touches them.

    always_comb begin
        next_sense_pos_sel   = ~cfg.amp_input_select;
        next_phase_node_sel  = cfg.amp_input_select;
        next_ref_half        = cfg.ref_halving_select;
        next_lowside_ref_neg = cfg.lowside_vds_ref_select;
        next_amp_gain        = cfg.amp_gain_select;
        next_sense_fault_en  = ~cfg.sense_fault_disable;
        next_amp_short       = cfg.amp_offset_cal;
        next_trip_level      = cfg.sense_trip_level;
        next_sense_oc_fault  = sense_oc_raw && !cfg.sense_fault_disable;
    end

    // Controls are registered so the analog switches never see decode glitches.
    // Their reset values come from the register default, so the two can never disagree.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sense_pos_sel   <= ~CSACTL_RESET[CSACTL_BIT_INSEL];
            phase_node_sel  <= CSACTL_RESET[CSACTL_BIT_INSEL];
            ref_half        <= CSACTL_RESET[CSACTL_BIT_REFHALF];
            lowside_ref_neg <= CSACTL_RESET[CSACTL_BIT_LSREF];
            amp_gain        <= CSACTL_RESET[CSACTL_BIT_GAIN_LO +: 2];
            sense_fault_en  <= ~CSACTL_RESET[CSACTL_BIT_SENDIS];
            amp_short       <= CSACTL_RESET[CSACTL_BIT_CAL_C +: CSACTL_NUM_AMPS];
            trip_level      <= CSACTL_RESET[CSACTL_BIT_TRIP_LO +: 2];
            sense_oc_fault  <= 1'b0;
        end else begin
            sense_pos_sel   <= next_sense_pos_sel;
            phase_node_sel  <= next_phase_node_sel;
            ref_half        <= next_ref_half;
            lowside_ref_neg <= next_lowside_ref_neg;
            amp_gain        <= next_amp_gain;
            sense_fault_en  <= next_sense_fault_en;
            amp_short       <= next_amp_short;
            trip_level      <= next_trip_level;
            sense_oc_fault  <= next_sense_oc_fault;
        end
    end
endmodule
`default_nettype wire

// file: csactl_reg_asserts.sv
// Checker for the current sense control bank.
// Assumes it is bound to csactl_reg.
`timescale 1ns/1ps
`default_nettype none
module csactl_reg_asserts (
    // Bank ports
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire csactl_pkg::csactl_req_t req,
    input wire logic [15:0] rdata,
    input wire logic        rvalid,
    input wire logic        sense_pos_sel,
    input wire logic        phase_node_sel,
    input wire logic        ref_half,
    input wire logic        lowside_ref_neg,
    input wire logic [1:0]  amp_gain,
    input wire logic        sense_fault_en,
    input wire logic [2:0]  amp_short,
    input wire logic [1:0]  trip_level,
    input wire logic        sense_oc_raw,
    input wire logic        sense_oc_fault
);
    import csactl_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    chk_read_answer: assert property (req.rd_en |=> rvalid) else $error("read unanswered");
    chk_high_zero: assert property (rvalid |-> rdata[15:11] == 5'h0) else $error("high bits set");
    chk_unmapped_read: assert property (req.rd_en && req.addr != CSACTL_ADDR_CSA |=> rdata == 16'h0)
        else $error("unmapped read");
    chk_input_pair: assert property (sense_pos_sel != phase_node_sel) else $error("input select");
    chk_ref_forced: assert property (req.wr_en && req.addr == CSACTL_ADDR_CSA && req.wdata[10]
        |=> ##1 lowside_ref_neg) else $error("reference not forced");
    chk_fault_gate: assert property ($past(resetn)
        |-> sense_oc_fault == ($past(sense_oc_raw) && sense_fault_en)) else $error("fault gate");
    chk_field_load: assert property (req.wr_en && req.addr == CSACTL_ADDR_CSA ##1 !req.wr_en
        |=> {amp_gain, amp_short, trip_level} ==
            {$past(req.wdata[7:6], 2), $past(req.wdata[4:2], 2), $past(req.wdata[1:0], 2)})
        else $error("field load");
    chk_unmapped_write: assert property (req.wr_en && req.addr != CSACTL_ADDR_CSA ##1 !req.wr_en
        |=> $stable({amp_gain, trip_level, ref_half})) else $error("unmapped write");
endmodule
bind csactl_reg csactl_reg_asserts u_chk (.core_clk, .resetn, .req, .rdata, .rvalid, .sense_pos_sel,
    .phase_node_sel, .ref_half, .lowside_ref_neg, .amp_gain, .sense_fault_en, .amp_short, .trip_level,
    .sense_oc_raw, .sense_oc_fault);
`default_nettype wire

// file: csactl_host.sv
// Host model issuing register requests.
// Assumes the bench calls acc.
`timescale 1ns/1ps
`default_nettype none
module csactl_host (
    // Clock and request
    input  wire logic                    core_clk,
    output var  csactl_pkg::csactl_req_t req
);
    import csactl_pkg::*;
    initial req = '0;
    // Released fields show inverted values so a stale latch cannot pass.
    task automatic acc(input logic wr, input logic [3:0] a, input logic [15:0] d);
        @(negedge core_clk);
        req <= {wr, !wr, a, d};
        @(negedge core_clk);
        req <= {2'b00, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// file: test_current_sense_amp_control_reg.sv
// Bench for the current sense control bank.
// Assumes csactl_host and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_current_sense_amp_control_reg;
    import csactl_pkg::*;
    logic        core_clk = 0, resetn = 0, sense_oc_raw = 0;
    logic [15:0] rdata;
    logic        rvalid, sense_pos_sel, phase_node_sel, ref_half, lowside_ref_neg, sense_fault_en, sense_oc_fault;
    logic [1:0]  amp_gain, trip_level;
    logic [2:0]  amp_short;
    logic [10:0] m;
    logic [12:0] seen_ctl, exp_ctl;
    csactl_req_t req;
    integer      seed = 89, err_count = 0, checks = 0, cyc = 0;
    csactl_host host (.core_clk(core_clk), .req(req));
    csactl_reg dut (.core_clk, .resetn, .req, .rdata, .rvalid, .sense_pos_sel, .phase_node_sel, .ref_half,
        .lowside_ref_neg, .amp_gain, .sense_fault_en, .amp_short, .trip_level, .sense_oc_raw, .sense_oc_fault);
    initial forever #50 core_clk = ~core_clk;
    always @(posedge core_clk) if (++cyc == 3000) begin err_count++; conclude(); end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Expected word after a write: high bits drop, and a set input select forces the reference bit.
    function automatic logic [10:0] exp_word(input logic [15:0] d);
        exp_word = d[10] ? d[10:0] | 11'h100 : d[10:0];
    endfunction
    // Read back, then compare the answer and every decoded control against the model word.
    task automatic cmp_all();
        host.acc(0, CSACTL_ADDR_CSA, 16'h0);
        seen_ctl = {phase_node_sel, sense_pos_sel, ref_half, lowside_ref_neg, amp_gain, sense_fault_en, amp_short,
            trip_level, sense_oc_fault};
        exp_ctl = {m[10], !m[10], m[9:5] ^ 5'h1, m[4:0], sense_oc_raw & !m[5]};
        chk(rdata, {5'h0, m});
        chk(16'(rvalid), 16'h0001);
        chk(16'(seen_ctl), 16'(exp_ctl));
    endtask
    task automatic wr_rd(input logic [3:0] a, input logic [15:0] d);
        sense_oc_raw <= 1'($random(seed));
        host.acc(1, a, d);
        if (a == CSACTL_ADDR_CSA) m = exp_word(d);
        cmp_all();
    endtask
    task automatic conclude();
        $display("checks %0d, err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        m = CSACTL_RESET;
        repeat (10) @(negedge core_clk);
        resetn = 1;
        cmp_all();
        wr_rd(CSACTL_ADDR_CSA, 16'hFC00);
        for (int i = 0; i < 40; i++) wr_rd(i % 5 ? CSACTL_ADDR_CSA : 4'($random(seed)) | 4'h8, 16'($random(seed)));
        host.acc(0, 4'h3, 16'h0);
        chk(rdata, 16'h0);
        chk(16'(rvalid), 16'h0001);
        // A second reset in mid-run must bring back the default word and every control.
        @(negedge core_clk) resetn = 0;
        repeat (10) @(negedge core_clk);
        resetn = 1;
        m = CSACTL_RESET;
        cmp_all();
        conclude();
    end
endmodule
`default_nettype wire
